// ==== rtl/tms_pkg.sv ====
// constants, types and timing for the touch matrix scanner
// assumes a single 100 MHz clock and a 16 x 8 key matrix sampled synchronously
package tms_pkg;
    localparam int COL_W         = 4;
    localparam int ROW_W         = 3;
    localparam int POS_W         = COL_W + ROW_W;
    localparam int KEYS          = 1 << POS_W;
    localparam int CNT_W         = 32;

    // timing, times in microseconds, clock in nanoseconds
    localparam int CLK_PERIOD_NS = 10;
    localparam int HIT_TIME_US   = 2000;
    localparam int DONE_TIME_US  = 4000;
    localparam int DWELL_TIME_US = 250;
    localparam int SWEEP_MAX_US  = 64000;
    // least times round up to whole cycles
    localparam int HIT_CYC   = (HIT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DONE_CYC  = (DONE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // dwell per position bounds the sweep, so it rounds down
    localparam int DWELL_CYC = (DWELL_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int SWEEP_MAX_CYC = (SWEEP_MAX_US * 1000) / CLK_PERIOD_NS;

    localparam logic [POS_W-1:0] LAST_IDX = 7'h7F;
    localparam logic [ROW_W-1:0] ROW_TOP  = 3'h0;
    localparam logic [ROW_W-1:0] ROW_BOT  = 3'h7;

    // reported position, column in upper bits
    typedef struct packed {
        logic [COL_W-1:0] col;
        logic [ROW_W-1:0] row;
    } tms_pos_t;

    localparam tms_pos_t POS_RESET = '{col: 4'h0, row: 3'h0};

    typedef enum logic [1:0] {
        TMS_IDLE,
        TMS_SWEEP,
        TMS_HIT,
        TMS_DONE
    } tms_state_t;
endpackage

// ==== rtl/tms_timer.sv ====
// down counter giving the length of each scanner phase
// assumes load and ce come from the same clock domain
`timescale 1ns/100ps
module tms_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic              expired
);
    logic [W-1:0] cnt;

    // refuse a counter too narrow to hold a phase length
    if (W < 2) begin : g_bad_width
        $error("tms_timer: width too small");
    end

    // load holds n-1 so a phase lasts exactly n enabled cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (ce) begin
            if (load) begin
                cnt <= load_val - W'(1);
            end else if (cnt != '0) begin
                cnt <= cnt - W'(1);
            end
        end
    end

    assign expired = (cnt == '0);
endmodule // tms_timer

// ==== rtl/tms_scanner.sv ====
// auto-scanning encoder for the 16 x 8 touch matrix
// assumes key_matrix and the control pins are synchronous to clk and debounced
// enough upstream; bit index of key_matrix is column * 8 + row
`timescale 1ns/100ps
module tms_scanner #(
    parameter int HIT_CYCLES   = tms_pkg::HIT_CYC,
    parameter int DONE_CYCLES  = tms_pkg::DONE_CYC,
    parameter int DWELL_CYCLES = tms_pkg::DWELL_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    input  wire logic                      force_full_sweep_n,
    input  wire logic                      sense_arm_n,
    input  wire logic [tms_pkg::KEYS-1:0]  key_matrix,
    output logic [tms_pkg::COL_W-1:0]      col_code,
    output logic [tms_pkg::ROW_W-1:0]      row_code,
    output logic                           key_hit_n,
    output logic                           sweep_done
);
    import tms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    tms_state_t       state;
    tms_state_t       next_state;
    logic [POS_W-1:0] idx;
    tms_pos_t         codes;
    logic             timer_load;
    logic [CNT_W-1:0] timer_val;
    logic             expired;
    logic             any_touch;
    logic             want_sweep;
    logic             here_touched;

    // zero-length phases would skip a position or a pulse, so refuse them
    if (HIT_CYCLES < 1 || DONE_CYCLES < 1 || DWELL_CYCLES < 1) begin : g_bad_counts
        $error("tms_scanner: phase counts must be at least one cycle");
    end

    // sweep order: columns left to right, rows bottom to top, so the last find
    // in a sweep is the highest priority key
    function automatic tms_pos_t pos_of(input logic [POS_W-1:0] i);
        tms_pos_t p;
        p.col = i[POS_W-1:ROW_W];
        p.row = ROW_BOT - i[ROW_W-1:0];
        return p;
    endfunction

    function automatic logic touched_at(input logic [KEYS-1:0] m, input tms_pos_t p);
        return m[{p.col, p.row}];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // start and continue conditions

    assign any_touch    = |key_matrix;
    assign want_sweep   = !force_full_sweep_n || (!sense_arm_n && any_touch);
    assign here_touched = touched_at(key_matrix, pos_of(idx));

    ////////////////////////////////////////////////////////////////////////////////
    // next state and phase timer load

    always_comb begin
        next_state = state;
        timer_load = 1'b0;
        timer_val  = CNT_W'(DWELL_CYCLES);
        unique case (state)
            TMS_IDLE: begin
                if (want_sweep) begin
                    next_state = TMS_SWEEP;
                    timer_load = 1'b1;
                end
            end
            TMS_SWEEP: begin
                if (expired) begin
                    timer_load = 1'b1;
                    if (here_touched) begin
                        next_state = TMS_HIT;
                        timer_val  = CNT_W'(HIT_CYCLES);
                    end else if (idx == LAST_IDX) begin
                        next_state = TMS_DONE;
                        timer_val  = CNT_W'(DONE_CYCLES);
                    end
                end
            end
            TMS_HIT: begin
                if (expired) begin
                    timer_load = 1'b1;
                    if (idx == LAST_IDX) begin
                        next_state = TMS_DONE;
                        timer_val  = CNT_W'(DONE_CYCLES);
                    end else begin
                        next_state = TMS_SWEEP;
                    end
                end
            end
            TMS_DONE: begin
                if (expired) begin
                    if (want_sweep) begin
                        next_state = TMS_SWEEP;
                        timer_load = 1'b1;
                    end else begin
                        next_state = TMS_IDLE;
                    end
                end
            end
        endcase
    end

    tms_timer #(
        .W        (CNT_W)
    ) u_timer (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .load     (timer_load),
        .load_val (timer_val),
        .expired  (expired)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= TMS_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // scan position: advances after each empty dwell or hit, cleared to zero in idle and done for a new sweep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx <= '0;
        end else if (ce) begin
            if (state == TMS_IDLE || state == TMS_DONE) begin
                idx <= '0;
            end else if (next_state == TMS_SWEEP && timer_load && state != TMS_IDLE) begin
                idx <= idx + POS_W'(1);
            end
        end
    end

    // codes change only when a hit begins, so they survive idle and done
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            codes <= POS_RESET;
        end else if (ce && state == TMS_SWEEP && next_state == TMS_HIT) begin
            codes <= pos_of(idx);
        end
    end

    // pulse outputs follow the next state so they line up with the phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_hit_n  <= 1'b1;
            sweep_done <= 1'b0;
        end else if (ce) begin
            key_hit_n  <= (next_state != TMS_HIT);
            sweep_done <= (next_state == TMS_DONE);
        end
    end

    assign col_code = codes.col;
    assign row_code = codes.row;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [CNT_W-1:0] hit_len;
    logic [CNT_W-1:0] done_len;
    logic [CNT_W-1:0] sweep_len;

    // measure pulse widths and sweep length in enabled cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_len   <= '0;
            done_len  <= '0;
            sweep_len <= '0;
        end else if (ce) begin
            hit_len   <= !key_hit_n ? hit_len + CNT_W'(1) : '0;
            done_len  <= sweep_done ? done_len + CNT_W'(1) : '0;
            sweep_len <= (state == TMS_SWEEP || state == TMS_HIT) ? sweep_len + CNT_W'(1) : '0;
        end
    end

    sequence s_hit_start;
        ce && state == TMS_SWEEP && next_state == TMS_HIT;
    endsequence

    sequence s_hit_shown;
        !key_hit_n && codes == $past(pos_of(idx));
    endsequence

    property p_code_latch;
        @(posedge clk) disable iff (rst) s_hit_start |=> s_hit_shown;
    endproperty
    a_code_latch: assert property (p_code_latch) else $error("codes not latched at hit");

    property p_code_hold;
        @(posedge clk) disable iff (rst)
            (codes != $past(codes)) |-> (!key_hit_n && $past(key_hit_n));
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("codes changed outside hit");

    property p_hit_real;
        @(posedge clk) disable iff (rst)
            s_hit_start |-> touched_at(key_matrix, pos_of(idx));
    endproperty
    a_hit_real: assert property (p_hit_real) else $error("hit on untouched key");

    property p_hit_width;
        @(posedge clk) disable iff (rst)
            (ce && $rose(key_hit_n)) |-> hit_len == CNT_W'(HIT_CYCLES);
    endproperty
    a_hit_width: assert property (p_hit_width) else $error("hit strobe width wrong");

    property p_done_width;
        @(posedge clk) disable iff (rst)
            (ce && $fell(sweep_done)) |-> done_len == CNT_W'(DONE_CYCLES);
    endproperty
    a_done_width: assert property (p_done_width) else $error("done pulse width wrong");

    property p_force_runs;
        @(posedge clk) disable iff (rst)
            (ce && !force_full_sweep_n && state == TMS_IDLE) |=> state == TMS_SWEEP;
    endproperty
    a_force_runs: assert property (p_force_runs) else $error("forced sweep not started");

    property p_arm_start;
        @(posedge clk) disable iff (rst)
            (ce && !sense_arm_n && any_touch && state == TMS_IDLE) |=> state == TMS_SWEEP;
    endproperty
    a_arm_start: assert property (p_arm_start) else $error("armed touch did not start");

    property p_stay_idle;
        @(posedge clk) disable iff (rst)
            (ce && state == TMS_IDLE && force_full_sweep_n && (sense_arm_n || !any_touch))
            |=> state == TMS_IDLE && $stable(codes);
    endproperty
    a_stay_idle: assert property (p_stay_idle) else $error("left idle without cause");

    property p_done_codes;
        @(posedge clk) disable iff (rst) sweep_done |-> key_hit_n && $stable(codes);
    endproperty
    a_done_codes: assert property (p_done_codes) else $error("codes moved during done");

    property p_sweep_bound;
        @(posedge clk) disable iff (rst)
            (state == TMS_SWEEP) |-> sweep_len <= CNT_W'(SWEEP_MAX_CYC);
    endproperty
    a_sweep_bound: assert property (p_sweep_bound) else $error("sweep too long");
endmodule // tms_scanner

// ==== tb/tms_host_model.sv ====
// host model: counts hit strobes, times both pulses, captures codes
// assumes registered scanner outputs, sampled on the rising clock edge
`timescale 1ns/100ps
module tms_host_model (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  key_hit_n,
    input  wire logic                  sweep_done,
    input  wire logic [tms_pkg::COL_W-1:0] col_code,
    input  wire logic [tms_pkg::ROW_W-1:0] row_code,
    output tms_pkg::tms_pos_t          first_pos,
    output tms_pkg::tms_pos_t          done_pos,
    output int                         sweep_hits,
    output int                         total_hits,
    output int                         hit_len,
    output int                         done_len
);
    import tms_pkg::*;
    logic hit_q;
    logic done_q;
    int   hits;
    int   hit_run;
    int   done_run;
    ////////////////////////////////////////////////////////////////////////
    // strobe fall is the host interrupt; codes are read in that same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_q      <= 1'b1;
            done_q     <= 1'b0;
            hits       <= 0;
            total_hits <= 0;
            sweep_hits <= 0;
            first_pos  <= POS_RESET;
            done_pos   <= POS_RESET;
        end else begin
            hit_q  <= key_hit_n;
            done_q <= sweep_done;
            if (!key_hit_n && hit_q) begin
                hits       <= hits + 1;
                total_hits <= total_hits + 1;
                if (hits == 0) first_pos <= '{col_code, row_code};
            end
            if (sweep_done && !done_q) begin
                done_pos   <= '{col_code, row_code};
                sweep_hits <= hits;
                hits       <= 0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // pulse widths in clock cycles, stored when each pulse ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hit_run  <= 0;
            done_run <= 0;
            hit_len  <= 0;
            done_len <= 0;
        end else begin
            hit_run  <= key_hit_n ? 0 : hit_run + 1;
            done_run <= sweep_done ? done_run + 1 : 0;
            if (key_hit_n && hit_run != 0) hit_len <= hit_run;
            if (!sweep_done && done_run != 0) done_len <= done_run;
        end
    end
endmodule // tms_host_model

// ==== tb/tb.sv ====
// testbench for the touch matrix scanner with shortened timing
// assumes inputs change on the falling edge; ce is held high except during the clock enable test
`timescale 1ns/100ps
module tb;
    import tms_pkg::*;
    localparam int H = 3;
    localparam int E = 5;
    localparam int D = 2;
    localparam int BOUND = 128 * D + 16 * H + 20;
    typedef struct { int a; int b; tms_pos_t first; tms_pos_t win; int hits; } tms_row_t;
    // key index is col*8+row; scan runs col up, row bottom to top
    tms_row_t rows [5] = '{
        '{7, -1, '{4'h0, 3'h7}, '{4'h0, 3'h7}, 1},
        '{120, -1, '{4'hF, 3'h0}, '{4'hF, 3'h0}, 1},
        '{60, 90, '{4'h7, 3'h4}, '{4'hB, 3'h2}, 2},
        '{60, 25, '{4'h3, 3'h1}, '{4'h7, 3'h4}, 2},
        '{89, 88, '{4'hB, 3'h1}, '{4'hB, 3'h0}, 2}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic force_n = 1'b1;
    logic arm_n = 1'b1;
    logic ce = 1'b1;
    logic [KEYS-1:0] keys = '0;
    logic [COL_W-1:0] col_code;
    logic [ROW_W-1:0] row_code;
    logic key_hit_n;
    logic sweep_done;
    tms_pos_t first_pos;
    tms_pos_t done_pos;
    int sweep_hits, total_hits, hit_len, done_len;
    int failures = 0;
    int checks_done = 0;
    ////////////////////////////////////////////////////////////////////////
    tms_scanner #(.HIT_CYCLES(H), .DONE_CYCLES(E), .DWELL_CYCLES(D)) tms_scanner_inst (
        .clk(clk), .rst(rst), .ce(ce), .force_full_sweep_n(force_n),
        .sense_arm_n(arm_n), .key_matrix(keys), .col_code(col_code),
        .row_code(row_code), .key_hit_n(key_hit_n), .sweep_done(sweep_done));
    tms_host_model tms_host_model_inst (
        .clk(clk), .rst(rst), .key_hit_n(key_hit_n), .sweep_done(sweep_done),
        .col_code(col_code), .row_code(row_code), .first_pos(first_pos),
        .done_pos(done_pos), .sweep_hits(sweep_hits), .total_hits(total_hits),
        .hit_len(hit_len), .done_len(done_len));
    initial begin
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check_v(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // bounded wait for the done pulse level; one extra cycle lets the host catch up
    task automatic wait_done(input logic lvl);
        int n;
        n = 0;
        while (sweep_done !== lvl) begin
            @(negedge clk);
            n++;
            if (n > BOUND) begin
                failures++;
                conclude();
            end
        end
        @(negedge clk);
    endtask
    // bounded wait for a hit strobe level
    task automatic wait_hit(input logic lvl);
        int n;
        n = 0;
        while (key_hit_n !== lvl) begin
            @(negedge clk);
            n++;
            if (n > BOUND) begin
                failures++;
                conclude();
            end
        end
    endtask
    // a sweep left running would raise done within this span
    task automatic idle_watch();
        logic seen;
        seen = 1'b0;
        repeat (BOUND) begin
            @(negedge clk);
            if (sweep_done !== 1'b0) seen = 1'b1;
        end
        check_v(seen, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check_v({col_code, row_code}, POS_RESET);
        check_v({key_hit_n, sweep_done}, 2'b10);
        // touch while neither armed nor forced
        keys[5] = 1'b1;
        idle_watch();
        check_v(total_hits, 0);
        $display("unarmed touch test done");
        keys = '0;
        arm_n = 1'b0;
        foreach (rows[i]) begin
            keys[rows[i].a] = 1'b1;
            if (rows[i].b >= 0) keys[rows[i].b] = 1'b1;
            wait_done(1'b1);
            check_v(done_pos, rows[i].win);
            check_v(first_pos, rows[i].first);
            check_v(sweep_hits, rows[i].hits);
            check_v(hit_len, H);
            keys = '0;
            wait_done(1'b0);
            idle_watch();
            check_v({col_code, row_code}, rows[i].win);
            $display("row %0d done", i);
        end
        // forced sweeps with nothing touched run back to back
        arm_n = 1'b1;
        force_n = 1'b0;
        wait_done(1'b1);
        wait_done(1'b0);
        @(negedge clk);
        check_v(done_len, E);
        wait_done(1'b1);
        check_v({col_code, row_code}, rows[4].win);
        force_n = 1'b1;
        wait_done(1'b0);
        idle_watch();
        $display("forced sweep test done");
        // clock enable low in mid-strobe freezes the strobe and the codes
        arm_n = 1'b0;
        keys[7] = 1'b1;
        wait_hit(1'b0);
        ce = 1'b0;
        repeat (10) @(negedge clk);
        check_v({key_hit_n, sweep_done}, 2'b00);
        check_v({col_code, row_code}, rows[0].win);
        ce = 1'b1;
        keys = '0;
        arm_n = 1'b1;
        wait_hit(1'b1);
        @(negedge clk);
        check_v(hit_len, H + 10);
        $display("clock enable test done");
        // reset in mid-sweep clears codes and pulses and leaves the scanner idle
        rst = 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check_v({col_code, row_code}, POS_RESET);
        check_v({key_hit_n, sweep_done}, 2'b10);
        idle_watch();
        check_v(total_hits, 0);
        $display("mid-run reset test done");
        conclude();
    end
endmodule // tb
